// file: include/osc_pkg.sv
/*
 * Shared constants of the oscillator switch and PLL control block: register
 * offsets, field positions, reset values, source encodings and timing counts.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package osc_pkg;

	// Register byte offsets on the Avalon-MM bus.
	localparam logic [3:0] OSC_OFS_CONTROL = 4'h0;
	localparam logic [3:0] OSC_OFS_CLOCK_DIVIDER_CONTROL = 4'h4;
	localparam logic [3:0] OSC_OFS_TRIM = 4'h8;
	localparam logic [3:0] OSC_OFS_DISPDIV = 4'hc;

	// Oscillator control register field positions.
	localparam int OSC_ACT_LSB = 12;
	localparam int OSC_TGT_LSB = 8;
	localparam int OSC_LOCK_BIT = 5;
	localparam int OSC_FAIL_BIT = 3;
	localparam int OSC_SEC_BIT = 1;
	localparam int OSC_REQ_BIT = 0;

	// Clock divider register field positions.
	localparam int OSC_PLLON_BIT = 5;
	localparam int OSC_GSEL_BIT = 4;

	// Display divider field position and width.
	localparam int OSC_DDIV_LSB = 9;
	localparam int OSC_DDIV_W = 7;

	// Trim field width.
	localparam int OSC_TRIM_W = 6;

	// Unlock key bytes for the two halves of the control register.
	localparam logic [7:0] OSC_KEY_HI_A = 8'h78;
	localparam logic [7:0] OSC_KEY_HI_B = 8'h9a;
	localparam logic [7:0] OSC_KEY_LO_A = 8'h46;
	localparam logic [7:0] OSC_KEY_LO_B = 8'h57;

	// Reset values.
	localparam logic [15:0] OSC_CLOCK_DIVIDER_CONTROL_RST = 16'h0100;
	localparam logic [15:0] OSC_TRIM_RST = 16'h0000;
	localparam logic [15:0] OSC_DDIV_RST = 16'h0000;

	// Cycles of the new clock counted before changeover.
	localparam int OSC_SWITCH_CYCLES = 10;

	// Start-up and lock wait times, in nanoseconds, and derived cycle counts.
	localparam int OSC_CLK_NS = 50;
	localparam int OSC_OST_NS = 51200;
	localparam int OSC_LOCK_NS = 100000;
	localparam int OSC_OST_CYC = (OSC_OST_NS + OSC_CLK_NS - 1) / OSC_CLK_NS;
	localparam int OSC_LOCK_CYC = (OSC_LOCK_NS + OSC_CLK_NS - 1) / OSC_CLK_NS;

	// Clock source encodings of the active and target source fields.
	localparam logic [2:0] OSC_SRC_FRC = 3'h0;
	localparam logic [2:0] OSC_SRC_FAST_RC_WITH_PLL = 3'h1;
	localparam logic [2:0] OSC_SRC_PRI = 3'h2;
	localparam logic [2:0] OSC_SRC_PRIPLL = 3'h3;
	localparam logic [2:0] OSC_SRC_SEC = 3'h4;
	localparam logic [2:0] OSC_SRC_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] OSC_SRC_FRC16 = 3'h6;
	localparam logic [2:0] OSC_SRC_FRCDIV = 3'h7;

	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		OSC_ST_IDLE = 5'b00001,
		OSC_ST_START = 5'b00010,
		OSC_ST_LOCK = 5'b00100,
		OSC_ST_COUNT = 5'b01000,
		OSC_ST_DONE = 5'b10000
	} osc_state_e;

endpackage

// file: core/osc_disp_div.sv
/*
 * Display clock divisor decoder: maps the 7-bit divider code to a divisor
 * in quarter units and emits a one-cycle enable at that average rate.
 * Assumes the caller gates it with the PLL enable.
 */
`timescale 1ns/10ps
`default_nettype none

module osc_disp_div
	import osc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Control.
	input wire logic run,
	input wire logic [OSC_DDIV_W-1:0] code,
	// Result.
	output logic [8:0] divisor_q4,
	output logic tick
);

	logic [8:0] quarters;
	logic [8:0] acc_q;

	////////////////////////////////////////////////////////////////////////
	// RULE_06 divisor code map
	always_comb begin
		if (code <= 7'h40) begin
			quarters = 9'h004 + {2'h0, code};
		end else if (code <= 7'h60) begin
			quarters = 9'h044 + {1'h0, code - 7'h40, 1'b0};
		end else begin
			quarters = 9'h084 + {code - 7'h60, 2'h0};
		end
	end

	assign divisor_q4 = quarters;

	// Fractional divider: adds four quarters per input cycle, so the
	// enable rate averages input/divisor; jitter is the price of no PLL.
	always_ff @(posedge clk_sys) begin
		if (rst || !run) begin
			acc_q <= 9'h000;
			tick <= 1'b0;
		end else if (acc_q + 9'h004 >= quarters) begin
			acc_q <= acc_q + 9'h004 - quarters;
			tick <= 1'b1;
		end else begin
			acc_q <= acc_q + 9'h004;
			tick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: core/osc_ctrl.sv
/*
 * Oscillator switch sequencer and 96 MHz PLL control with an Avalon-MM
 * register slave. Assumes oscillator ready levels come from other clock
 * domains and are synchronised here; configuration straps are static.
 */
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Function
// RULE_01 - PLL must run whenever USB or graphics is enabled.
// RULE_02 - Clock divider bit 5 turns the PLL on or off.
// RULE_03 - Configuration override enables PLL; otherwise the software bit does.
// RULE_04 - Bit 4 selects 96 MHz or 48 MHz branch for graphics.
// RULE_05 - Six-bit trim is signed; zero is centre frequency.
// RULE_06 - Display divisor steps 0.25, then 0.5, then 1, up to 64.
// RULE_07 - On 48 MHz branch every display frequency is halved.
// RULE_08 - Display divider only takes effect with PLL enabled.
// RULE_09 - Unprogrammed switch config disables switching and fail-safe monitor.
// RULE_10 - Switching disabled: target ignored, active shows initial config.
// RULE_11 - Switching disabled: request bit has no effect, reads zero.
// RULE_12 - High byte writable only after keys 78h then 9Ah.
// RULE_13 - Low byte writable only after keys 46h then 57h.
// RULE_14 - Equal active and target sources abort and clear request.
// RULE_15 - Valid switch start clears lock flag and clock fail flag.
// RULE_16 - Start target; wait start-up timer for crystal, lock for PLL.
// RULE_17 - Count ten new-clock cycles, then change over.
// RULE_18 - On completion clear request and copy target to active.
// RULE_19 - Stop old source unless watchdog, fail-safe or secondary enable hold it.
// RULE_20 - Software must not switch directly between the two PLL modes.
// RULE_21 - PLL multiplies 4 MHz by 24 to 96 MHz, three branches.
// RULE_22 - Software sets prescaler config so its output is 4 MHz.
// RULE_23 - Source codes: FAST_INTERNAL_RC, FAST_RC_WITH_PLL, primary, primary PLL, SECONDARY_OSC, LOW_POWER_RC, FAST_INTERNAL_RC/16, FRCDIV.
module osc_ctrl
	import osc_pkg::*;
#(
	parameter int OST_CYCLES = OSC_OST_CYC,
	parameter int LOCK_CYCLES = OSC_LOCK_CYC
)(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Configuration straps.
	input wire logic switch_allow_config,
	input wire logic pll_config_override,
	input wire logic [2:0] initial_source_config,
	input wire logic wdt_enabled,
	// Ready and failure levels from the oscillators, asynchronous.
	input wire logic [7:0] src_ready_async,
	input wire logic clk_fail_async,
	// Oscillator and clock tree controls.
	output logic [7:0] src_run_q,
	output logic [2:0] sys_clk_sel_q,
	output logic pll_run_q,
	output logic gfx_sel_96_q,
	output logic disp_clk_en_q,
	output logic [OSC_TRIM_W-1:0] rc_trim_q,
	output logic failsafe_monitor_q
);

	localparam int CW = 20;

	// Both waits share one counter of CW bits, so larger counts cannot be served.
	if (OST_CYCLES < 1 || LOCK_CYCLES < 1 ||
		OST_CYCLES >= 2 ** CW || LOCK_CYCLES >= 2 ** CW) begin : g_bad_wait
		$error("osc_ctrl: wait counts out of range");
	end

	logic [7:0] rdy_s1_q;
	logic [7:0] rdy_s2_q;
	logic fail_s1_q;
	logic fail_s2_q;
	logic [15:0] clock_divider_control_q;
	logic [15:0] trim_q;
	logic [15:0] ddiv_q;
	logic [2:0] active_q;
	logic [2:0] target_q;
	logic req_q;
	logic lock_q;
	logic fail_q;
	logic sec_on_q;
	logic [1:0] key_hi_q;
	logic [1:0] key_lo_q;
	logic ack_q;
	logic [CW-1:0] cnt_q;
	logic [2:0] old_q;
	logic [3:0] tick_cnt_q;
	osc_state_e state_q;
	logic switch_en;
	logic acc;
	logic wr_ctl_hi;
	logic wr_ctl_lo;
	logic disp_tick;
	logic [8:0] disp_q4;
	logic tgt_pll;
	logic tgt_xtal;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the oscillator ready and failure levels.
	always_ff @(posedge clk_sys) begin
		rdy_s1_q <= src_ready_async;
		rdy_s2_q <= rdy_s1_q;
		fail_s1_q <= clk_fail_async;
		fail_s2_q <= fail_s1_q;
	end

	// RULE_09 switching enable strap
	assign switch_en = ~switch_allow_config;
	// RULE_23 source code decode
	assign tgt_pll = (target_q == OSC_SRC_FAST_RC_WITH_PLL) || (target_q == OSC_SRC_PRIPLL);
	assign tgt_xtal = (target_q == OSC_SRC_PRI) || (target_q == OSC_SRC_PRIPLL) ||
		(target_q == OSC_SRC_SEC);

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, then the access completes.
	assign acc = (avs_read || avs_write) && !ack_q;
	assign avs_waitrequest = ~ack_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc;
		end
	end

	// Completing write strobes into the control register halves.
	assign wr_ctl_hi = ack_q && avs_write && avs_address == OSC_OFS_CONTROL && avs_byteenable[1];
	assign wr_ctl_lo = ack_q && avs_write && avs_address == OSC_OFS_CONTROL && avs_byteenable[0];

	// Read data, registered in the wait cycle so it stands at the ack edge.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (acc && avs_read) begin
			case (avs_address)
				// RULE_11 request reads zero when disabled
				OSC_OFS_CONTROL: avs_readdata <= {17'h00000, active_q, 1'b0, target_q,
					2'h0, lock_q, 1'b0, fail_q, 1'b0, sec_on_q, req_q & switch_en};
				OSC_OFS_CLOCK_DIVIDER_CONTROL: avs_readdata <= {16'h0000, clock_divider_control_q};
				OSC_OFS_TRIM: avs_readdata <= {16'h0000, trim_q};
				OSC_OFS_DISPDIV: avs_readdata <= {16'h0000, ddiv_q};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RULE_12 high byte unlock keys
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			key_hi_q <= 2'h0;
		end else if (wr_ctl_hi) begin
			if (avs_writedata[15:8] == OSC_KEY_HI_A) begin
				key_hi_q <= 2'h1;
			end else if (key_hi_q == 2'h1 && avs_writedata[15:8] == OSC_KEY_HI_B) begin
				key_hi_q <= 2'h2;
			end else begin
				key_hi_q <= 2'h0;
			end
		end else if (ack_q) begin
			key_hi_q <= 2'h0;
		end
	end

	// RULE_13 low byte unlock keys
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			key_lo_q <= 2'h0;
		end else if (wr_ctl_lo) begin
			if (avs_writedata[7:0] == OSC_KEY_LO_A) begin
				key_lo_q <= 2'h1;
			end else if (key_lo_q == 2'h1 && avs_writedata[7:0] == OSC_KEY_LO_B) begin
				key_lo_q <= 2'h2;
			end else begin
				key_lo_q <= 2'h0;
			end
		end else if (ack_q) begin
			key_lo_q <= 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Target source field; RULE_10 ignored while switching is disabled.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			target_q <= OSC_SRC_FRC;
		end else if (wr_ctl_hi && key_hi_q == 2'h2 && switch_en) begin
			target_q <= avs_writedata[OSC_TGT_LSB +: 3];
		end
	end

	// Secondary oscillator enable is plain software state.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sec_on_q <= 1'b0;
		end else if (wr_ctl_lo && key_lo_q == 2'h2) begin
			sec_on_q <= avs_writedata[OSC_SEC_BIT];
		end
	end

	// Plain software registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clock_divider_control_q <= OSC_CLOCK_DIVIDER_CONTROL_RST;
			trim_q <= OSC_TRIM_RST;
			ddiv_q <= OSC_DDIV_RST;
		end else if (ack_q && avs_write) begin
			case (avs_address)
				OSC_OFS_CLOCK_DIVIDER_CONTROL: clock_divider_control_q <= avs_writedata[15:0] & 16'hfff0;
				// RULE_05 signed trim field stored
				OSC_OFS_TRIM: trim_q <= {10'h000, avs_writedata[OSC_TRIM_W-1:0]};
				OSC_OFS_DISPDIV: ddiv_q <= avs_writedata[15:0] & 16'hfe00;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switch sequencer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= OSC_ST_IDLE;
			req_q <= 1'b0;
			active_q <= OSC_SRC_FRC;
			old_q <= OSC_SRC_FRC;
			cnt_q <= '0;
			tick_cnt_q <= 4'h0;
		end else if (!switch_en) begin
			// RULE_10 active follows initial config
			state_q <= OSC_ST_IDLE;
			req_q <= 1'b0;
			active_q <= initial_source_config;
		end else begin
			case (state_q)
				OSC_ST_IDLE: begin
					if (wr_ctl_lo && key_lo_q == 2'h2 && avs_writedata[OSC_REQ_BIT]) begin
						// RULE_14 redundant switch abort
						if (target_q == active_q) begin
							req_q <= 1'b0;
						end else begin
							req_q <= 1'b1;
							old_q <= active_q;
							cnt_q <= '0;
							state_q <= OSC_ST_START;
						end
					end
				end
				// RULE_16 start-up timer wait
				OSC_ST_START: begin
					if (rdy_s2_q[target_q] && (!tgt_xtal ||
						cnt_q >= CW'(OST_CYCLES))) begin
						cnt_q <= '0;
						state_q <= tgt_pll ? OSC_ST_LOCK : OSC_ST_COUNT;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				// RULE_16 PLL lock wait
				OSC_ST_LOCK: begin
					if (cnt_q >= CW'(LOCK_CYCLES)) begin
						tick_cnt_q <= 4'h0;
						state_q <= OSC_ST_COUNT;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				// RULE_17 ten new-clock cycles
				OSC_ST_COUNT: begin
					if (tick_cnt_q == 4'(OSC_SWITCH_CYCLES - 1)) begin
						state_q <= OSC_ST_DONE;
					end else begin
						tick_cnt_q <= tick_cnt_q + 4'h1;
					end
				end
				// RULE_18 complete and copy target
				OSC_ST_DONE: begin
					req_q <= 1'b0;
					active_q <= target_q;
					tick_cnt_q <= 4'h0;
					state_q <= OSC_ST_IDLE;
				end
				default: state_q <= OSC_ST_IDLE;
			endcase
		end
	end

	// Lock flag; RULE_15 cleared at a valid switch start.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lock_q <= 1'b0;
		end else if (state_q == OSC_ST_IDLE && wr_ctl_lo && key_lo_q == 2'h2 &&
			avs_writedata[OSC_REQ_BIT] && target_q != active_q && switch_en) begin
			lock_q <= 1'b0;
		end else if (state_q == OSC_ST_LOCK && cnt_q >= CW'(LOCK_CYCLES)) begin
			lock_q <= 1'b1;
		end else if (state_q == OSC_ST_IDLE && active_q != OSC_SRC_FAST_RC_WITH_PLL &&
			active_q != OSC_SRC_PRIPLL) begin
			lock_q <= 1'b0;
		end
	end

	// Clock fail flag; RULE_15 cleared at start, but a new failure wins.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fail_q <= 1'b0;
		end else if (fail_s2_q && switch_en) begin
			fail_q <= 1'b1;
		end else if (state_q == OSC_ST_IDLE && wr_ctl_lo && key_lo_q == 2'h2 &&
			avs_writedata[OSC_REQ_BIT] && target_q != active_q) begin
			fail_q <= 1'b0;
		end else if (wr_ctl_lo && key_lo_q == 2'h2 && !avs_writedata[OSC_FAIL_BIT]) begin
			fail_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RULE_19 oscillator run enables
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			src_run_q <= 8'h01;
		end else begin
			for (int i = 0; i < 8; i++) begin
				src_run_q[i] <= (3'(i) == active_q) ||
					(3'(i) == target_q && state_q != OSC_ST_IDLE) ||
					(3'(i) == OSC_SRC_LOW_POWER_RC && (wdt_enabled || switch_en)) ||
					(3'(i) == OSC_SRC_SEC && sec_on_q);
			end
		end
	end

	// System clock select follows the active field.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sys_clk_sel_q <= OSC_SRC_FRC;
		end else begin
			sys_clk_sel_q <= active_q;
		end
	end

	// RULE_01 RULE_02 RULE_03 RULE_21 PLL enable with override
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pll_run_q <= 1'b0;
			gfx_sel_96_q <= 1'b0;
			rc_trim_q <= '0;
			failsafe_monitor_q <= 1'b0;
		end else begin
			pll_run_q <= pll_config_override | clock_divider_control_q[OSC_PLLON_BIT];
			// RULE_04 graphics branch select
			gfx_sel_96_q <= clock_divider_control_q[OSC_GSEL_BIT];
			rc_trim_q <= trim_q[OSC_TRIM_W-1:0];
			// RULE_09 monitor follows the strap
			failsafe_monitor_q <= switch_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RULE_08 divider runs only with PLL on
	osc_disp_div u_disp_div (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(pll_run_q),
		.code(ddiv_q[OSC_DDIV_LSB +: OSC_DDIV_W]),
		.divisor_q4(disp_q4),
		.tick(disp_tick)
	);

	// RULE_07 output enable marks the divided branch; the 48 MHz halving
	// is applied by the branch itself, which gfx_sel_96_q selects.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			disp_clk_en_q <= 1'b0;
		end else begin
			disp_clk_en_q <= disp_tick && pll_run_q && disp_q4 != 9'h000;
		end
	end

	// RULE_14 abort leaves sequencer idle
	a_abort_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == OSC_ST_IDLE && wr_ctl_lo && key_lo_q == 2'h2 && switch_en &&
		avs_writedata[OSC_REQ_BIT] && target_q == active_q) |=> state_q == OSC_ST_IDLE)
		else $error("redundant switch did not abort");

	// RULE_17 count phase length
	a_count_ten: assert property (@(posedge clk_sys) disable iff (rst || !switch_en)
		$rose(state_q == OSC_ST_COUNT) |-> (state_q == OSC_ST_COUNT) [*8] ##1
		(state_q == OSC_ST_COUNT) [*2] ##1 state_q == OSC_ST_DONE)
		else $error("changeover count is not ten cycles");

	// RULE_18 completion copies target
	a_done_copy: assert property (@(posedge clk_sys) disable iff (rst || !switch_en)
		state_q == OSC_ST_DONE |=> active_q == $past(target_q) && !req_q)
		else $error("completed switch did not update source");

	// RULE_11 request reads zero when disabled
	a_req_zero: assert property (@(posedge clk_sys) disable iff (rst)
		!switch_en |=> !req_q)
		else $error("request set while switching disabled");

	// RULE_03 PLL override
	a_pll_override: assert property (@(posedge clk_sys) disable iff (rst)
		pll_config_override |=> pll_run_q)
		else $error("override did not enable the PLL");

	// RULE_15 lock cleared on start
	a_lock_clear: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(state_q == OSC_ST_START) |-> !lock_q)
		else $error("lock flag not cleared at switch start");

	// RULE_08 no display enable without PLL
	a_disp_gate: assert property (@(posedge clk_sys) disable iff (rst)
		!pll_run_q |=> !disp_clk_en_q)
		else $error("display clock ran without PLL");

	// RULE_12 high byte locked without keys
	a_hi_locked: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ctl_hi && key_hi_q != 2'h2) |=> target_q == $past(target_q))
		else $error("target written without unlock");

endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench of the oscillator switch and PLL control block.
 * Assumes the block answers every register access after one wait cycle
 * and that the oscillator ready levels may be held high throughout.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import osc_pkg::*;

	// Clock, reset and register bus.
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, last_rd;
	// Straps, oscillator levels and clock tree controls.
	logic switch_allow_config, pll_config_override, wdt_enabled, clk_fail_async;
	logic [2:0] initial_source_config, sys_clk_sel_q, tgt;
	logic [7:0] src_ready_async, src_run_q;
	logic pll_run_q, gfx_sel_96_q, disp_clk_en_q, failsafe_monitor_q;
	logic [OSC_TRIM_W-1:0] rc_trim_q;
	// Bench bookkeeping: expected reads as {mask, value}.
	int err_total, check_count, ticks, r;
	logic [63:0] exp_q[$];
	logic [6:0] codes[7] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h60, 7'h7f, 7'h00};
	logic [5:0] trims[4] = '{6'h1f, 6'h20, 6'h00, 6'h00};
	logic [2:0] plain[4] = '{3'h2, 3'h4, 3'h6, 3'h7};

	// Short start-up and lock waits keep the run brief.
	osc_ctrl #(.OST_CYCLES(4), .LOCK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.switch_allow_config(switch_allow_config), .pll_config_override(pll_config_override),
		.initial_source_config(initial_source_config), .wdt_enabled(wdt_enabled),
		.src_ready_async(src_ready_async), .clk_fail_async(clk_fail_async),
		.src_run_q(src_run_q), .sys_clk_sel_q(sys_clk_sel_q), .pll_run_q(pll_run_q),
		.gfx_sel_96_q(gfx_sel_96_q), .disp_clk_en_q(disp_clk_en_q), .rc_trim_q(rc_trim_q),
		.failsafe_monitor_q(failsafe_monitor_q));

	////////////////////////////////////////////////////////////////////////
	// A 50 ns clock for the 20 MHz system domain.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Display enables are counted so that rates can be judged over a window.
	always @(posedge clk_sys) begin
		if (disp_clk_en_q === 1'b1) ticks <= ticks + 1;
	end

	// Reads with a note queued are compared at the edge that accepts them.
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) chk_rd(exp_q.pop_front());
	end

	////////////////////////////////////////////////////////////////////////
	task chk_rd(input logic [63:0] e);
		check_count++;
		if ((avs_readdata & e[63:32]) !== e[31:0]) begin
			err_total++;
			$display("BAD %0t read %h, expected %h under mask %h", $time, avs_readdata, e[31:0], e[63:32]);
		end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] ex);
		check_count++;
		if (got !== ex) begin
			err_total++;
			$display("BAD %0t port value %h, expected %h", $time, got, ex);
		end
	endtask

	// The request is held until waitrequest is seen low at a rising edge.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		last_rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, a, d, be);
	endtask

	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back({m, e});
		bus(1'b0, a, 32'h0, 4'hf);
	endtask

	// Both unlock sequences, then a poll until the request bit drops.
	task switch_to(input logic [2:0] t);
		wr(OSC_OFS_CONTROL, {16'h0, OSC_KEY_HI_A, 8'h00}, 4'h2);
		wr(OSC_OFS_CONTROL, {16'h0, OSC_KEY_HI_B, 8'h00}, 4'h2);
		wr(OSC_OFS_CONTROL, {16'h0, 5'h0, t, 8'h00}, 4'h2);
		wr(OSC_OFS_CONTROL, {24'h0, OSC_KEY_LO_A}, 4'h1);
		wr(OSC_OFS_CONTROL, {24'h0, OSC_KEY_LO_B}, 4'h1);
		wr(OSC_OFS_CONTROL, 32'h1, 4'h1);
		do bus(1'b0, OSC_OFS_CONTROL, 32'h0, 4'hf); while (last_rd[0] !== 1'b0);
	endtask

	// Counts enables over 512 cycles against the divisor in quarter units.
	task dcheck(input logic [6:0] code, input logic pll);
		int start;
		int q4;
		int ex;
		int got;
		wr(OSC_OFS_DISPDIV, {16'h0, code, 9'h0}, 4'h3);
		repeat (4) @(posedge clk_sys);
		start = ticks;
		repeat (512) @(posedge clk_sys);
		got = ticks - start;
		q4 = (code <= 64) ? 4 + code : (code <= 96) ? 68 + 2 * (code - 64) : 132 + 4 * (code - 96);
		ex = pll ? 2048 / q4 : 0;
		chk({31'h0, (got - ex <= 1) && (ex - got <= 1)}, 32'h1);
	endtask

	task finish_test;
		if (exp_q.size() != 0) err_total++;
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the few thousand cycles expected.
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		finish_test;
	end

	////////////////////////////////////////////////////////////////////////
	// First pass runs with switching disabled, the second with it enabled.
	initial begin
		{rst, avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = {1'b1, 42'h0};
		{switch_allow_config, pll_config_override, wdt_enabled, clk_fail_async} = 4'b1010;
		initial_source_config = OSC_SRC_PRI;
		src_ready_async = 8'hff;
		{err_total, check_count, ticks} = 0;
		r = $urandom(2);
		codes[6] = 7'($urandom_range(127));
		trims[3] = 6'($urandom);
		tgt = plain[$urandom_range(3)];
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(OSC_OFS_CLOCK_DIVIDER_CONTROL, {16'h0, OSC_CLOCK_DIVIDER_CONTROL_RST}, 32'hffffffff);
		rd(OSC_OFS_TRIM, 32'h0, 32'hffffffff);
		rd(OSC_OFS_DISPDIV, 32'h0, 32'hffffffff);
		rd(4'h2, 32'h0, 32'hffffffff);
		rd(OSC_OFS_CONTROL, {17'h0, OSC_SRC_PRI, 12'h0}, 32'h7001);
		chk({31'h0, failsafe_monitor_q}, 32'h0);
		switch_to(tgt);
		rd(OSC_OFS_CONTROL, {17'h0, OSC_SRC_PRI, 12'h0}, 32'h7001);
		chk({29'h0, sys_clk_sel_q}, {29'h0, OSC_SRC_PRI});
		// Walk both clock divider control bits, ending with both clear.
		for (int i = 3; i >= 0; i--) begin
			wr(OSC_OFS_CLOCK_DIVIDER_CONTROL, {16'h0, 8'h01, 2'(i), 4'h0}, 4'h3);
			rd(OSC_OFS_CLOCK_DIVIDER_CONTROL, {16'h0, 8'h01, 2'(i), 4'h0}, 32'hffffffff);
			repeat (2) @(posedge clk_sys);
			chk({31'h0, pll_run_q}, 32'(i / 2));
			chk({31'h0, gfx_sel_96_q}, 32'(i % 2));
		end
		pll_config_override <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({31'h0, pll_run_q}, 32'h1);
		pll_config_override <= 1'b0;
		foreach (trims[i]) begin
			wr(OSC_OFS_TRIM, {26'h0, trims[i]}, 4'h3);
			rd(OSC_OFS_TRIM, {26'h0, trims[i]}, 32'hffffffff);
			chk({26'h0, rc_trim_q}, {26'h0, trims[i]});
		end
		wr(OSC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0000_0120, 4'h3);
		foreach (codes[i]) dcheck(codes[i], 1'b1);
		chk({31'h0, gfx_sel_96_q}, 32'h0);
		wr(OSC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0000_0100, 4'h3);
		dcheck(7'h00, 1'b0);
		rst <= 1'b1;
		switch_allow_config <= 1'b0;
		initial_source_config <= OSC_SRC_FRC;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({31'h0, failsafe_monitor_q}, 32'h1);
		// A broken key must leave the target field alone.
		wr(OSC_OFS_CONTROL, {16'h0, OSC_KEY_HI_A, 8'h00}, 4'h2);
		wr(OSC_OFS_CONTROL, 32'h0, 4'h2);
		wr(OSC_OFS_CONTROL, {16'h0, 5'h0, tgt, 8'h00}, 4'h2);
		rd(OSC_OFS_CONTROL, 32'h0, 32'h7701);
		clk_fail_async <= 1'b1;
		repeat (4) @(posedge clk_sys);
		clk_fail_async <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(OSC_OFS_CONTROL, 32'h8, 32'h8);
		switch_to(tgt);
		rd(OSC_OFS_CONTROL, {17'h0, tgt, 1'b0, tgt, 8'h00}, 32'h772b);
		chk({29'h0, sys_clk_sel_q}, {29'h0, tgt});
		chk({30'h0, src_run_q[0], src_run_q[5]}, 32'h1);
		// Leaving for the PLL mode always passes through plain FAST_INTERNAL_RC.
		switch_to(OSC_SRC_FRC);
		// prescaler assumed set for a 4 MHz input outside this block.
		switch_to(OSC_SRC_FAST_RC_WITH_PLL);
		rd(OSC_OFS_CONTROL, 32'h0000_1120, 32'h772b);
		switch_to(OSC_SRC_FRC);
		switch_to(OSC_SRC_FRC);
		rd(OSC_OFS_CONTROL, 32'h0, 32'h7701);
		finish_test;
	end

endmodule

`default_nettype wire
